// ### hw/cdcfg_bank.sv
// chip sync and downconverter configuration bank with its sample-side effects
// assumes samples arrive on mclk with a valid strobe, sysref arrives from a pin
`timescale 1ns/1ps
module cdcfg_bank (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // register port
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // sysref pin
  input wire logic sysref_pin,
  // converter samples
  input wire logic sample_valid,
  input wire logic [cdcfg_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [cdcfg_pkg::SAMPLE_W-1:0] sample_q,
  // output words
  output logic out_valid,
  output logic [cdcfg_pkg::SAMPLE_W-1:0] out_i,
  output logic [cdcfg_pkg::SAMPLE_W-1:0] out_q,
  output logic out_q_valid,
  output logic out_ctrl,
  // chip configuration and status
  output logic [3:0] ddc_enable,
  output logic downconverter_zero,
  output logic ddc_bypass,
  output logic [1:0] divider_phase,
  output logic link_up,
  output logic link_realign,
  output logic monitor_restart
);

  ////////////////////////////////////////////////////////////////////////
  // decoding functions

  // decimation code to divider terminal count, unknown codes act as by 1
  function automatic logic [1:0] dec_term(input logic [3:0] code);
    logic [1:0] t;
    t = cdcfg_pkg::TERM_BY1;
    unique case (code)
      cdcfg_pkg::DEC_BY2: t = cdcfg_pkg::TERM_BY2;
      cdcfg_pkg::DEC_BY3: t = cdcfg_pkg::TERM_BY3;
      cdcfg_pkg::DEC_BY4: t = cdcfg_pkg::TERM_BY4;
      default: t = cdcfg_pkg::TERM_BY1;
    endcase
    return t;
  endfunction

  // application code to downconverter enables
  function automatic logic [3:0] app_enables(input logic [3:0] code);
    logic [3:0] e;
    e = 4'h0;
    unique case (code)
      cdcfg_pkg::APP_ONE: e = 4'h1;
      cdcfg_pkg::APP_TWO: e = 4'h3;
      cdcfg_pkg::APP_FOUR: e = 4'hF;
      default: e = 4'h0;
    endcase
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] sysref_divider_sync_select;
  logic [7:0] ddc_application_select;
  logic [7:0] output_decimation_select;
  logic timestamp_mode;
  logic q_drop;
  logic [3:0] app_code;
  logic [3:0] dec_code;
  logic [1:0] term;

  assign timestamp_mode = sysref_divider_sync_select[cdcfg_pkg::SYNC_MODE_BIT];
  assign q_drop = ddc_application_select[cdcfg_pkg::Q_DROP_BIT];
  assign app_code = ddc_application_select[cdcfg_pkg::FIELD_MSB:cdcfg_pkg::FIELD_LSB];
  assign dec_code = output_decimation_select[cdcfg_pkg::FIELD_MSB:cdcfg_pkg::FIELD_LSB];
  assign term = dec_term(dec_code);

  // sync mode register, reserved bits masked off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sysref_divider_sync_select <= cdcfg_pkg::RST_SYNC;
    end else if (clk_en && reg_wr && (reg_addr == cdcfg_pkg::ADDR_SYNC)) begin
      sysref_divider_sync_select <= reg_wdata & cdcfg_pkg::MASK_SYNC;
    end
  end

  // application register, reserved bits masked off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ddc_application_select <= cdcfg_pkg::RST_APP;
    end else if (clk_en && reg_wr && (reg_addr == cdcfg_pkg::ADDR_APP)) begin
      ddc_application_select <= reg_wdata & cdcfg_pkg::MASK_APP;
    end
  end

  // decimation register, reserved bits masked off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      output_decimation_select <= cdcfg_pkg::RST_DEC;
    end else if (clk_en && reg_wr && (reg_addr == cdcfg_pkg::ADDR_DEC)) begin
      output_decimation_select <= reg_wdata & cdcfg_pkg::MASK_DEC;
    end
  end

  // read data one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        unique case (reg_addr)
          cdcfg_pkg::ADDR_SYNC: reg_rdata <= sysref_divider_sync_select;
          cdcfg_pkg::ADDR_APP: reg_rdata <= ddc_application_select;
          cdcfg_pkg::ADDR_DEC: reg_rdata <= output_decimation_select;
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sysref capture

  logic sysref_meta;
  logic sysref_sync;
  logic sysref_prev;
  logic sysref_event;

  // two-stage synchroniser, only the second stage is read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sysref_meta <= 1'b0;
      sysref_sync <= 1'b0;
    end else if (clk_en) begin
      sysref_meta <= sysref_pin;
      sysref_sync <= sysref_meta;
    end
  end

  // edge history, resets to the idle pin level so no false edge follows reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sysref_prev <= 1'b0;
    end else if (clk_en) begin
      sysref_prev <= sysref_sync;
    end
  end

  // rising edge of the synchronised level is one accepted event
  assign sysref_event = sysref_sync & ~sysref_prev;

  ////////////////////////////////////////////////////////////////////////
  // internal clock divider

  logic [1:0] div_cnt;
  logic div_reset;
  logic phase_change;
  logic [1:0] next_div_cnt;

  // only divider-reset mode lets sysref touch the divider
  assign div_reset = sysref_event & ~timestamp_mode;
  assign phase_change = div_reset & (next_div_cnt != 2'h0);

  // free-running phase, advanced by each sample
  always_comb begin
    next_div_cnt = div_cnt;
    if (sample_valid) begin
      next_div_cnt = (div_cnt >= term) ? 2'h0 : div_cnt + 2'h1;
    end
  end

  // divider, restarted by an accepted event in divider-reset mode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 2'h0;
    end else if (clk_en) begin
      if (div_reset) begin
        div_cnt <= 2'h0;
      end else begin
        div_cnt <= next_div_cnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link state

  cdcfg_pkg::cdcfg_link_t link_state;
  logic [3:0] down_cnt;

  // link drops on a forced phase change and comes back after a hold-off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link_state <= cdcfg_pkg::LINK_UP;
    end else if (clk_en) begin
      unique case (link_state)
        cdcfg_pkg::LINK_UP: begin
          if (phase_change) begin
            link_state <= cdcfg_pkg::LINK_DOWN;
          end
        end
        cdcfg_pkg::LINK_DOWN: begin
          if (!phase_change && (down_cnt == 4'h1)) begin
            link_state <= cdcfg_pkg::LINK_UP;
          end
        end
        default: begin
          link_state <= cdcfg_pkg::LINK_UP;
        end
      endcase
    end
  end

  // hold-off counter, reloaded by every forced phase change while down
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      down_cnt <= 4'h0;
    end else if (clk_en) begin
      if (phase_change) begin
        down_cnt <= cdcfg_pkg::LINK_DOWN_CYC;
      end else if (link_state == cdcfg_pkg::LINK_DOWN) begin
        down_cnt <= down_cnt - 4'h1;
      end else begin
        down_cnt <= 4'h0;
      end
    end
  end

  // link level, low from the forced phase change until the hold-off ends
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link_up <= 1'b1;
    end else if (clk_en) begin
      link_up <= (link_state == cdcfg_pkg::LINK_UP) & ~phase_change;
    end
  end

  // realign pulse, never raised in timestamp mode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link_realign <= 1'b0;
    end else if (clk_en) begin
      link_realign <= phase_change;
    end
  end

  // monitor restart pulse, follows only a divider reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      monitor_restart <= 1'b0;
    end else if (clk_en) begin
      monitor_restart <= div_reset;
    end
  end

  // divider phase as it will stand after this edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      divider_phase <= 2'h0;
    end else if (clk_en) begin
      divider_phase <= div_reset ? 2'h0 : next_div_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timestamp marking

  logic mark_pending;
  logic out_take;

  // a sample is kept when the divider sits at phase zero
  assign out_take = sample_valid & (div_cnt == 2'h0);

  // event with no sample kept this cycle waits for the next kept one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mark_pending <= 1'b0;
    end else if (clk_en) begin
      if (!timestamp_mode) begin
        mark_pending <= 1'b0;
      end else if (out_take) begin
        mark_pending <= 1'b0;
      end else if (sysref_event) begin
        mark_pending <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output word

  // word strobes, the q strobe goes away with the quadrature path
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_q_valid <= 1'b0;
    end else if (clk_en) begin
      out_valid <= out_take;
      out_q_valid <= out_take & ~q_drop;
    end
  end

  // timestamp control bit riding on the kept word
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_ctrl <= 1'b0;
    end else if (clk_en) begin
      out_ctrl <= out_take & timestamp_mode & (sysref_event | mark_pending);
    end
  end

  // word data, held between kept samples
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_i <= '0;
      out_q <= '0;
    end else if (clk_en && out_take) begin
      out_i <= sample_i;
      out_q <= q_drop ? '0 : sample_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // downconverter configuration outputs

  // enables follow the application field
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ddc_enable <= 4'h0;
      downconverter_zero <= 1'b0;
    end else if (clk_en) begin
      ddc_enable <= app_enables(app_code);
      downconverter_zero <= app_enables(app_code) != 4'h0;
    end
  end

  // bypass at full rate, unknown decimation codes included
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ddc_bypass <= 1'b1;
    end else if (clk_en) begin
      ddc_bypass <= (term == cdcfg_pkg::TERM_BY1);
    end
  end

endmodule

// ### hw/cdcfg_pkg.sv
// package for the chip sync and downconverter configuration bank
// assumes a byte-wide register port with printed offsets as addresses
//
// Summary of operation
// - sync bit 0: every accepted sysref event resets all internal dividers
// - sync bit 0: a divider forced to change phase takes the link down
// - sync bit 1: sysref leaves all internal dividers untouched
// - sync bit 1: link state and signal monitor ignore sysref
// - sync bit 1: the first kept sample at or after a sysref event is marked
// - sync bit 1: the mark travels as a control bit of its output word
// - bit 5 at 1 drops quadrature output, at 0 both paths are produced
// - application field picks none, one, two or four downconverters
// - decimation field: 0000 by 1, 0001 by 2, 1000 by 3, 0010 by 4
package cdcfg_pkg;
  // register addresses
  localparam logic [9:0] ADDR_SYNC = 10'h1FF;
  localparam logic [9:0] ADDR_APP = 10'h200;
  localparam logic [9:0] ADDR_DEC = 10'h201;
  // reset values
  localparam logic [7:0] RST_SYNC = 8'h00;
  localparam logic [7:0] RST_APP = 8'h00;
  localparam logic [7:0] RST_DEC = 8'h00;
  // writable bit masks, everything else reserved
  localparam logic [7:0] MASK_SYNC = 8'h01;
  localparam logic [7:0] MASK_APP = 8'h2F;
  localparam logic [7:0] MASK_DEC = 8'h0F;
  // field positions
  localparam int SYNC_MODE_BIT = 0;
  localparam int Q_DROP_BIT = 5;
  localparam int FIELD_LSB = 0;
  localparam int FIELD_MSB = 3;
  // application mode codes
  localparam logic [3:0] APP_FULL = 4'h0;
  localparam logic [3:0] APP_ONE = 4'h1;
  localparam logic [3:0] APP_TWO = 4'h2;
  localparam logic [3:0] APP_FOUR = 4'h3;
  // decimation codes and resulting divider terminal counts
  localparam logic [3:0] DEC_BY1 = 4'h0;
  localparam logic [3:0] DEC_BY2 = 4'h1;
  localparam logic [3:0] DEC_BY3 = 4'h8;
  localparam logic [3:0] DEC_BY4 = 4'h2;
  localparam logic [1:0] TERM_BY1 = 2'h0;
  localparam logic [1:0] TERM_BY2 = 2'h1;
  localparam logic [1:0] TERM_BY3 = 2'h2;
  localparam logic [1:0] TERM_BY4 = 2'h3;
  // datapath width and link recovery length in mclk cycles
  localparam int SAMPLE_W = 14;
  localparam logic [3:0] LINK_DOWN_CYC = 4'h8;
  // link state, one-hot
  typedef enum logic [1:0] {
    LINK_UP = 2'b01,
    LINK_DOWN = 2'b10
  } cdcfg_link_t;
endpackage

// ### testbench/cdcfg_bank_assertions.sv
// port checker for the configuration bank
// assumes clk_en held high and the bind below
`timescale 1ns/1ps
module cdcfg_bank_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // watched outputs
  input wire logic out_valid,
  input wire logic out_q_valid,
  input wire logic out_ctrl,
  input wire logic [3:0] ddc_enable,
  input wire logic downconverter_zero,
  input wire logic link_up,
  input wire logic link_realign,
  input wire logic monitor_restart
);
  logic ts_mode;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // shadow of the sync mode bit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) ts_mode <= 1'b0;
    else if (reg_wr && reg_addr == cdcfg_pkg::ADDR_SYNC) ts_mode <= reg_wdata[0];
  end
  // steps of a read and a link drop
  sequence s_sync_read;
    reg_rd && reg_addr == cdcfg_pkg::ADDR_SYNC;
  endsequence
  sequence s_link_held;
    !link_up [*8];
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_sync_rsvd: assert property (s_sync_read |=> reg_rdata[7:1] == 7'h00)
    else $error("sync reserved bits set");
  a_app_rsvd: assert property ((reg_rd && reg_addr == cdcfg_pkg::ADDR_APP)
    |=> (reg_rdata & ~cdcfg_pkg::MASK_APP) == 8'h00) else $error("app reserved bits set");
  a_qdrop_pair: assert property (out_q_valid |-> out_valid)
    else $error("q word without i word");
  a_ddc_map: assert property (ddc_enable inside {4'h0, 4'h1, 4'h3, 4'hF}
    && downconverter_zero == (ddc_enable != 4'h0)) else $error("bad converter enables");
  a_realign_down: assert property (link_realign |-> s_link_held)
    else $error("link not held down");
  a_realign_restart: assert property (link_realign |-> monitor_restart)
    else $error("realign without divider reset");
  a_ts_quiet: assert property ((link_realign || monitor_restart) |-> !ts_mode)
    else $error("sysref disturbed timestamp mode");
  a_mark_word: assert property (out_ctrl |-> out_valid)
    else $error("mark outside output word");
endmodule
////////////////////////////////////////////////////////////////
bind cdcfg_bank cdcfg_bank_chk u_chk (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .out_valid(out_valid), .out_q_valid(out_q_valid), .out_ctrl(out_ctrl),
  .ddc_enable(ddc_enable), .downconverter_zero(downconverter_zero), .link_up(link_up),
  .link_realign(link_realign), .monitor_restart(monitor_restart));

// ### testbench/cdcfg_bank_tb.sv
// self-checking bench for the configuration bank
// assumes one 50 MHz clock, clk_en tied high
`timescale 1ns/1ps
module cdcfg_bank_tb;
  logic mclk = 0, reset_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, sysref_pin = 0;
  logic sample_valid = 0, rd_pend = 0, out_valid, out_q_valid, out_ctrl, ddc_bypass;
  logic link_up, link_realign, monitor_restart, downconverter_zero;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [cdcfg_pkg::SAMPLE_W-1:0] sample_i = '0, sample_q = '0, out_i, out_q;
  logic [3:0] ddc_enable;
  logic [1:0] divider_phase;
  logic [7:0] exp_q[$];
  logic [27:0] exp_w[$];
  logic word_qz = 0;
  logic [3:0] en_tab[4] = '{4'h0, 4'h1, 4'h3, 4'hF};
  logic [7:0] dec_tab[4] = '{8'h00, 8'h01, 8'h08, 8'h02};
  int miscompares = 0, checks_done = 0, cyc = 0, nv, nq, nc, nd, nr, na, word_n = 0, word_k = 0;
  integer seed = 32'hDD14;
  cdcfg_bank u_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sysref_pin(sysref_pin), .sample_valid(sample_valid), .sample_i(sample_i),
    .sample_q(sample_q), .out_valid(out_valid), .out_i(out_i), .out_q(out_q),
    .out_q_valid(out_q_valid), .out_ctrl(out_ctrl), .ddc_enable(ddc_enable),
    .downconverter_zero(downconverter_zero), .ddc_bypass(ddc_bypass),
    .divider_phase(divider_phase), .link_up(link_up), .link_realign(link_realign),
    .monitor_restart(monitor_restart));
  ////////////////////////////////////////////////////////////////
  // clock
  initial begin
    forever #10 mclk = ~mclk;
  end
  // random samples, event counters, hang guard
  always @(posedge mclk) begin
    rd_pend <= reg_rd;
    sample_i <= $random(seed);
    sample_q <= $random(seed);
    nv += out_valid;
    nq += out_q_valid;
    nc += out_ctrl;
    nd += !link_up;
    nr += monitor_restart;
    na += link_realign;
    // expected words: every n-th valid sample of a run, divider starting at phase zero
    if (sample_valid && word_n > 0) begin
      if (word_k == 0) exp_w.push_back({sample_i, word_qz ? 14'h0000 : sample_q});
      word_k = (word_k + 1) % word_n;
    end
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  // read result watcher
  always @(negedge mclk) begin
    if (rd_pend) check(reg_rdata, exp_q.pop_front());
    if (out_valid && word_n > 0) check({out_i, out_q}, exp_w.pop_front());
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= w; reg_rd <= !w; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 0; reg_rd <= 0;
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(0, a, 8'h00);
  endtask
  task clr;
    @(negedge mclk);
    nv = 0;
    nq = 0;
    nc = 0;
    nd = 0;
    nr = 0;
    na = 0;
  endtask
  task run(input int n);
    clr();
    @(posedge mclk) sample_valid <= 1;
    repeat (n) @(posedge mclk);
    sample_valid <= 0;
    repeat (3) @(posedge mclk);
  endtask
  // stop the divider at count 3
  task freeze;
    @(posedge mclk) sample_valid <= 1;
    do @(negedge mclk); while (divider_phase !== 2'h2);
    @(posedge mclk) sample_valid <= 0;
  endtask
  task pulse_sys;
    @(posedge mclk) sysref_pin <= 1;
    repeat (3) @(posedge mclk);
    sysref_pin <= 0;
    repeat (14) @(posedge mclk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1;
    rd(cdcfg_pkg::ADDR_SYNC, cdcfg_pkg::RST_SYNC);
    rd(cdcfg_pkg::ADDR_APP, cdcfg_pkg::RST_APP);
    rd(cdcfg_pkg::ADDR_DEC, cdcfg_pkg::RST_DEC);
    bus(1, cdcfg_pkg::ADDR_SYNC, 8'hFE);
    bus(1, cdcfg_pkg::ADDR_APP, 8'hFF);
    bus(1, cdcfg_pkg::ADDR_DEC, 8'hF2);
    bus(1, 10'h202, 8'hFF);
    rd(cdcfg_pkg::ADDR_SYNC, 8'h00);
    rd(cdcfg_pkg::ADDR_APP, 8'h2F);
    rd(cdcfg_pkg::ADDR_DEC, 8'h02);
    rd(10'h202, 8'h00);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      bus(1, cdcfg_pkg::ADDR_APP, 8'(i) | (i[0] ? 8'h20 : 8'h00));
      bus(1, cdcfg_pkg::ADDR_DEC, dec_tab[i]);
      word_n = i + 1;
      word_k = 0;
      word_qz = i[0];
      run(24);
      check(ddc_enable, en_tab[i]);
      check(ddc_bypass, i == 0);
      check(downconverter_zero, i != 0);
      check(nv, 24 / (i + 1));
      check(nq, i[0] ? 0 : 24 / (i + 1));
      if (i[0]) check(out_q, 0);
    end
    word_n = 0;
    $display("modes done");
    freeze();
    clr();
    pulse_sys();
    check(nd, cdcfg_pkg::LINK_DOWN_CYC + 1);
    check(na, 1);
    check(nr, 1);
    check(divider_phase, 0);
    bus(1, cdcfg_pkg::ADDR_SYNC, 8'h01);
    freeze();
    clr();
    pulse_sys();
    check(nd, 0);
    check(nr, 0);
    check(na, 0);
    check(divider_phase, 3);
    clr();
    @(posedge mclk) sample_valid <= 1;
    pulse_sys();
    sample_valid <= 0;
    // the event seen with no sample left a mark for the first kept word, then one new mark
    check(nc, 2);
    $display("sysref done");
    wrap_up();
  end
endmodule
